// file: logic/serial_rx_message_delimiter.sv
// Purpose: Decide start and end of received messages from a char stream
// Assumes: One received character per valid pulse, at its stop bit
// Notes:   All state is one struct, registered once per enabled cycle
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "srmd_cfg.svh"

module serial_rx_message_delimiter #(
   parameter int MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   input  wire logic               clkEn,
   input  wire logic [7:0]         regAddr,
   input  wire logic [31:0]        regWdata,
   input  wire logic               regWr,
   input  wire logic               regRd,
   output logic [31:0]             regRdata,
   input  wire srmd_pkg::rxChar_t  rxIn,
   input  wire logic               receiveRequest,
   output srmd_pkg::msgChar_t      msgChar,
   output srmd_pkg::msgDone_t      msgDone
);
   import srmd_pkg::*;
   localparam logic [19:0] MS_PRE_LAST = 20'(MS_CYCLES - 1);
   state_t      s_q;
   state_t      s_d;
   logic [39:0] histNext;
   logic [2:0]  cntNext;
   logic [3:0]  sHit;
   logic        eHit;
   // ****************************************
   // Sequence matching
   // ****************************************
   // Newest character sits in the low byte of the history
   function automatic logic seqHit(input logic [39:0] chars,
                                   input logic [4:0]  en,
                                   input logic [39:0] h,
                                   input logic [2:0]  cnt,
                                   input logic        fullLen);
      int   hi = 4;
      int   back = 0;
      logic hit = (en != 5'h00);
      if (!fullLen) begin
         hi = 0;
         for (int i = 0; i < 5; i++) begin
            if (en[i]) begin
               hi = i;
            end
         end
      end
      for (int i = 0; i < 5; i++) begin
         if (en[i]) begin
            back = hi - i;
            if (int'(cnt) <= back || h[8*back +: 8] != chars[8*i +: 8]) begin
               hit = 1'b0;
            end
         end
      end
      return hit;
   endfunction
   assign histNext = {s_q.hist[31:0], rxIn.data};
   assign cntNext  = (s_q.histCnt == `HIST_MAX) ? `HIST_MAX
                                                : s_q.histCnt + 3'h1;
   generate
      for (genvar k = 0; k < 4; k++) begin : gSeq
         assign sHit[k] = seqHit(s_q.sSeq[k], s_q.sEn[k], histNext, cntNext,
                                 1'b0);
      end
   endgenerate
   assign eHit = seqHit(s_q.eSeq, s_q.eEn, histNext, cntNext, 1'b1);
   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic        baudTick;
      logic        msTick;
      logic        good;
      logic        acc;
      logic        fin;
      logic [1:0]  finCode;
      logic [15:0] newCnt;
      logic [16:0] lenLast;
      logic [31:0] lenNew;
      logic [33:0] lenTotal;
      logic        preOk;
      logic        charOk;
      logic        seqOk;
      logic [1:0]  seqIdx;
      s_d = s_q;
      acc = 1'b0;
      fin = 1'b0;
      finCode = `ERR_NONE;
      newCnt = s_q.count;
      lenNew = s_q.lenVal;
      lenTotal = 34'h0;
      seqIdx = regAddr[4:3];
      s_d.rdata = 32'h0;
      s_d.outChar.valid = 1'b0;
      s_d.outChar.first = 1'b0;
      s_d.outDone.valid = 1'b0;
      good = rxIn.valid && !rxIn.parityErr && !rxIn.framingErr;
      lenLast = 17'(s_q.lenPos) + 17'(s_q.lenSize) - 17'h00001;
      preOk = (!s_q.startMask[`SC_IDLE] || s_q.idleSeen ||
               s_q.bitCnt >= s_q.idleBits) &&
              (!s_q.startMask[`SC_BREAK] || s_q.breakSeen);
      charOk = !s_q.startMask[`SC_CHAR] || rxIn.data == s_q.startChar;
      seqOk = (s_q.startMask[`SC_SEQ +: 4] == 4'h0) ||
              ((sHit & s_q.startMask[`SC_SEQ +: 4]) != 4'h0);
      baudTick = (s_q.baudCnt >= s_q.baudDiv - 16'h0001);
      s_d.baudCnt = baudTick ? 16'h0000 : s_q.baudCnt + 16'h0001;
      msTick = (s_q.msPre >= MS_PRE_LAST);
      s_d.msPre = msTick ? 20'h00000 : s_q.msPre + 20'h00001;
      if (rxIn.valid) begin
         s_d.bitCnt = 16'h0000;
      end else if (baudTick && s_q.bitCnt != 16'hFFFF) begin
         s_d.bitCnt = s_q.bitCnt + 16'h0001;
      end
      if (msTick && s_q.msCnt != 16'hFFFF) begin
         s_d.msCnt = s_q.msCnt + 16'h0001;
      end
      // ****************************************
      // Register port
      // ****************************************
      if (regWr) begin
         if (regAddr[7:5] == `RA_SSEQ_BASE) begin
            if (!regAddr[2]) begin
               s_d.sSeq[seqIdx][31:0] = regWdata;
            end else begin
               s_d.sSeq[seqIdx][39:32] = regWdata[7:0];
               s_d.sEn[seqIdx] = regWdata[`SEQ_EN_LSB +: 5];
            end
         end
         unique case (regAddr)
            `RA_START_MASK: s_d.startMask = regWdata[7:0];
            `RA_END_MASK:   s_d.endMask = regWdata[5:0];
            `RA_IDLE_BITS:  s_d.idleBits = regWdata[15:0];
            `RA_START_CHAR: s_d.startChar = regWdata[7:0];
            `RA_BAUD_DIV:   s_d.baudDiv = regWdata[15:0];
            `RA_RESP_MS:    s_d.respMs = regWdata[15:0];
            `RA_MSG_MS:     s_d.msgMs = regWdata[15:0];
            `RA_GAP_BITS:   s_d.gapBits = regWdata[15:0];
            `RA_MAX_LEN:    s_d.maxLen = regWdata[15:0];
            `RA_LEN_POS:    s_d.lenPos = regWdata[15:0];
            `RA_LEN_TRAIL:  s_d.lenTrail = regWdata[15:0];
            `RA_END_SEQ_LO: s_d.eSeq[31:0] = regWdata;
            `RA_END_SEQ_HI: begin
               s_d.eSeq[39:32] = regWdata[7:0];
               s_d.eEn = regWdata[`SEQ_EN_LSB +: 5];
            end
            // only sizes 1, 2 and 4 are taken
            `RA_LEN_SIZE: begin
               if (regWdata == 32'h1 || regWdata == 32'h2 ||
                   regWdata == 32'h4) begin
                  s_d.lenSize = regWdata[2:0];
               end
            end
            default: ;
         endcase
      end
      if (regRd) begin
         if (regAddr[7:5] == `RA_SSEQ_BASE) begin
            s_d.rdata = regAddr[2] ?
               {19'h0, s_q.sEn[seqIdx], s_q.sSeq[seqIdx][39:32]} :
               s_q.sSeq[seqIdx][31:0];
         end
         unique case (regAddr)
            `RA_START_MASK: s_d.rdata = {24'h0, s_q.startMask};
            `RA_END_MASK:   s_d.rdata = {26'h0, s_q.endMask};
            `RA_IDLE_BITS:  s_d.rdata = {16'h0, s_q.idleBits};
            `RA_START_CHAR: s_d.rdata = {24'h0, s_q.startChar};
            `RA_BAUD_DIV:   s_d.rdata = {16'h0, s_q.baudDiv};
            `RA_RESP_MS:    s_d.rdata = {16'h0, s_q.respMs};
            `RA_MSG_MS:     s_d.rdata = {16'h0, s_q.msgMs};
            `RA_GAP_BITS:   s_d.rdata = {16'h0, s_q.gapBits};
            `RA_MAX_LEN:    s_d.rdata = {16'h0, s_q.maxLen};
            `RA_LEN_POS:    s_d.rdata = {16'h0, s_q.lenPos};
            `RA_LEN_SIZE:   s_d.rdata = {29'h0, s_q.lenSize};
            `RA_LEN_TRAIL:  s_d.rdata = {16'h0, s_q.lenTrail};
            `RA_END_SEQ_LO: s_d.rdata = s_q.eSeq[31:0];
            `RA_END_SEQ_HI: s_d.rdata = {19'h0, s_q.eEn, s_q.eSeq[39:32]};
            `RA_STATUS: s_d.rdata = {9'h0, s_q.histCnt, s_q.breakSeen,
                                     s_q.idleSeen, s_q.respArm, s_q.mode,
                                     s_q.count};
            default: ;
         endcase
      end
      // ****************************************
      // Framing
      // ****************************************
      // first arrival disarms response check only
      if (good) begin
         s_d.respArm = 1'b0;
      end
      unique case (s_q.mode)
         HUNT: begin
            // idle line latched once quiet long enough
            if (s_q.startMask[`SC_IDLE] && s_q.bitCnt >= s_q.idleBits) begin
               s_d.idleSeen = 1'b1;
            end
            if (rxIn.brk) begin
               s_d.breakSeen = 1'b1;
            end
            if (rxIn.valid && !good) begin
               s_d.histCnt = 3'h0;
            end else if (s_q.endMask[`EC_GAP] && s_q.histCnt != 3'h0 &&
                         s_q.bitCnt > s_q.gapBits) begin
               s_d.histCnt = 3'h0;
            end else if (good) begin
               s_d.hist = histNext;
               s_d.histCnt = cntNext;
            end
            if (good && preOk && charOk && seqOk &&
                s_q.startMask != 8'h00) begin
               s_d.mode = MSG;
               acc = 1'b1;
               newCnt = 16'h0001;
               lenNew = 32'h0;
               s_d.msCnt = 16'h0000;
               s_d.idleSeen = 1'b0;
               s_d.breakSeen = 1'b0;
               s_d.histCnt = 3'h1;
            end
            // no character before the response limit
            if (s_q.respArm && !good && s_q.msCnt >= s_q.respMs) begin
               s_d.respArm = 1'b0;
               s_d.outDone.valid = 1'b1;
               s_d.outDone.err = 1'b1;
               s_d.outDone.code = `ERR_RESP;
               s_d.outDone.length = 16'h0000;
            end
            if (receiveRequest) begin
               s_d.respArm = s_q.endMask[`EC_RESP];
               s_d.msCnt = 16'h0000;
            end
         end
         MSG: begin
            if (rxIn.valid && !good) begin
               fin = 1'b1;
               finCode = `ERR_LINE;
            end else if (good) begin
               acc = 1'b1;
               newCnt = (s_q.count == 16'hFFFF) ? s_q.count
                                                : s_q.count + 16'h0001;
               s_d.hist = histNext;
               s_d.histCnt = cntNext;
            end else if (s_q.endMask[`EC_GAP] &&
                         s_q.bitCnt > s_q.gapBits) begin
               fin = 1'b1;
               finCode = `ERR_GAP;
            end else if (s_q.endMask[`EC_MSG] &&
                         s_q.msCnt >= s_q.msgMs) begin
               fin = 1'b1;
            end
         end
      endcase
      if (acc) begin
         s_d.outChar.valid = 1'b1;
         s_d.outChar.data = rxIn.data;
         s_d.outChar.first = (s_q.mode == HUNT);
         s_d.count = newCnt;
         // big-endian length capture from position N
         if (s_q.lenPos != 16'h0000 && newCnt >= s_q.lenPos &&
             17'(newCnt) <= lenLast) begin
            lenNew = {lenNew[23:0], rxIn.data};
         end
         s_d.lenVal = lenNew;
         // position, length and trailer all received
         lenTotal = 34'(lenLast) + 34'(lenNew) + 34'(s_q.lenTrail);
         if (s_q.endMask[`EC_MAX] && newCnt >= s_q.maxLen) begin
            fin = 1'b1;
         end
         if (s_q.endMask[`EC_LEN] && s_q.lenPos != 16'h0000 &&
             17'(newCnt) >= lenLast && 34'(newCnt) >= lenTotal) begin
            fin = 1'b1;
         end
         if (s_q.endMask[`EC_SEQ] && eHit) begin
            fin = 1'b1;
         end
      end
      if (fin) begin
         s_d.mode = HUNT;
         s_d.histCnt = 3'h0;
         s_d.outDone.valid = 1'b1;
         s_d.outDone.err = (finCode != `ERR_NONE);
         s_d.outDone.code = finCode;
         s_d.outDone.length = newCnt;
      end
   end
   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.baudDiv <= `BAUD_DIV_RST;
         s_q.lenSize <= `LEN_SIZE_RST;
      end else if (clkEn) begin
         s_q <= s_d;
      end
   end
   assign regRdata = s_q.rdata;
   assign msgChar  = s_q.outChar;
   assign msgDone  = s_q.outDone;
endmodule

// file: logic/srmd_cfg.svh
// Purpose: Offsets, field positions, reset values and timing of the framer
// Assumes: Byte addresses on an 8-bit register address
// Notes:   Definitions only
`ifndef SRMD_CFG_SVH
`define SRMD_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define RA_START_MASK  8'h00
`define RA_END_MASK    8'h04
`define RA_IDLE_BITS   8'h08
`define RA_START_CHAR  8'h0C
`define RA_BAUD_DIV    8'h10
`define RA_RESP_MS     8'h14
`define RA_MSG_MS      8'h18
`define RA_GAP_BITS    8'h1C
`define RA_MAX_LEN     8'h20
`define RA_LEN_POS     8'h24
`define RA_LEN_SIZE    8'h28
`define RA_LEN_TRAIL   8'h2C
`define RA_STATUS      8'h30
`define RA_END_SEQ_LO  8'h60
`define RA_END_SEQ_HI  8'h64
`define RA_SSEQ_BASE   3'h2
`define SEQ_EN_LSB     8

// ****************************************
// Condition mask bits
// ****************************************
`define SC_CHAR   0
`define SC_ANY    1
`define SC_BREAK  2
`define SC_IDLE   3
`define SC_SEQ    4
`define EC_RESP   0
`define EC_MSG    1
`define EC_GAP    2
`define EC_MAX    3
`define EC_LEN    4
`define EC_SEQ    5

// ****************************************
// Reset values, codes and timing
// ****************************************
`define BAUD_DIV_RST   16'h5161
`define LEN_SIZE_RST   3'h1
`define HIST_MAX       3'h5
`define ERR_NONE       2'h0
`define ERR_RESP       2'h1
`define ERR_GAP        2'h2
`define ERR_LINE       2'h3
`define MS_NS          1000000
`define CLK_PERIOD_NS  5

`endif

// file: logic/srmd_pkg.sv
// Purpose: Types shared by the receive message framer
// Assumes: Eight-bit characters
// Notes:   Constants live in srmd_cfg.svh
package srmd_pkg;

   typedef enum logic {
      HUNT = 1'b0,
      MSG  = 1'b1
   } mode_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       parityErr;
      logic       framingErr;
      logic       brk;
   } rxChar_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       first;
   } msgChar_t;

   typedef struct packed {
      logic        valid;
      logic        err;
      logic [1:0]  code;
      logic [15:0] length;
   } msgDone_t;

   typedef struct packed {
      mode_t            mode;
      logic [7:0]       startMask;
      logic [5:0]       endMask;
      logic [15:0]      idleBits;
      logic [7:0]       startChar;
      logic [15:0]      baudDiv;
      logic [15:0]      respMs;
      logic [15:0]      msgMs;
      logic [15:0]      gapBits;
      logic [15:0]      maxLen;
      logic [15:0]      lenPos;
      logic [2:0]       lenSize;
      logic [15:0]      lenTrail;
      logic [3:0][39:0] sSeq;
      logic [3:0][4:0]  sEn;
      logic [39:0]      eSeq;
      logic [4:0]       eEn;
      logic [39:0]      hist;
      logic [2:0]       histCnt;
      logic [15:0]      baudCnt;
      logic [15:0]      bitCnt;
      logic [19:0]      msPre;
      logic [15:0]      msCnt;
      logic             respArm;
      logic             idleSeen;
      logic             breakSeen;
      logic [15:0]      count;
      logic [31:0]      lenVal;
      logic [31:0]      rdata;
      msgChar_t         outChar;
      msgDone_t         outDone;
   } state_t;

endpackage

// file: verification/serial_char_partner.sv
// Purpose: Character receiver and message consumer beside the framer
// Assumes: One character per call, a quiet cycle after each
// Notes:   Queues hold what the framer delivered
`timescale 1ns/1ps

module serial_char_partner (
   input  wire logic               core_clk,
   output srmd_pkg::rxChar_t       rxIn,
   input  wire srmd_pkg::msgChar_t msgChar,
   input  wire srmd_pkg::msgDone_t msgDone
);
   import srmd_pkg::*;

   msgChar_t gotQ[$];
   msgDone_t doneQ[$];

   initial rxIn = '0;

   // ****************************************
   // Source and sink
   // ****************************************
   // bad character on command
   task automatic send(input logic [7:0] d, input logic pe);
      @(posedge core_clk);
      rxIn <= {1'b1, d, pe, 2'b00};
      @(posedge core_clk);
      // Released data flips so a stale byte is never seen as valid
      rxIn <= {1'b0, ~d, 3'b000};
   endtask

   // line break ahead of a message
   task automatic brk_pulse();
      @(posedge core_clk);
      rxIn.brk <= 1'b1;
      @(posedge core_clk);
      rxIn.brk <= 1'b0;
   endtask

   always @(posedge core_clk) begin
      if (msgChar.valid === 1'b1) begin
         gotQ.push_back(msgChar);
      end
      if (msgDone.valid === 1'b1) begin
         doneQ.push_back(msgDone);
      end
   end
endmodule

// file: verification/serial_rx_message_delimiter_props.sv
// Purpose: Port checks of the receive message framer
// Assumes: clkEn held high
// Notes:   Max length and end mask shadowed from register writes
`timescale 1ns/1ps
`include "srmd_cfg.svh"

module serial_rx_message_delimiter_props #(
   parameter int MS_CYCLES = 10
) (
   input wire logic               core_clk,
   input wire logic               rst_n,
   input wire logic               clkEn,
   input wire logic [7:0]         regAddr,
   input wire logic [31:0]        regWdata,
   input wire logic               regWr,
   input wire logic               regRd,
   input wire logic [31:0]        regRdata,
   input wire srmd_pkg::rxChar_t  rxIn,
   input wire logic               receiveRequest,
   input wire srmd_pkg::msgChar_t msgChar,
   input wire srmd_pkg::msgDone_t msgDone
);
   import srmd_pkg::*;

   logic [15:0] cnt_q;
   logic [15:0] cntNow;
   logic [15:0] maxLen_q;
   logic [5:0]  endMask_q;

   assign cntNow = !msgChar.valid ? cnt_q :
                   (msgChar.first ? 16'h1 : cnt_q + 16'h1);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 16'h0;
         maxLen_q <= 16'h0;
         endMask_q <= 6'h0;
      end else if (clkEn) begin
         cnt_q <= msgDone.valid ? 16'h0 : cntNow;
         if (regWr && regAddr == `RA_MAX_LEN) begin
            maxLen_q <= regWdata[15:0];
         end
         if (regWr && regAddr == `RA_END_MASK) begin
            endMask_q <= regWdata[5:0];
         end
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // ****************************************
   // Assertions
   // ****************************************
   a_rdata_one_cycle: assert property (
      !$past(regRd) |-> regRdata == 32'h0) else $error("read data stale");
   a_unmapped_read_zero: assert property (
      regRd && regAddr == 8'hF0 |=> regRdata == 32'h0)
      else $error("unmapped read not zero");
   a_done_err_code: assert property (
      msgDone.valid |-> msgDone.err == (msgDone.code != 2'h0))
      else $error("error flag disagrees with code");
   a_resp_no_length: assert property (
      msgDone.valid && msgDone.code == `ERR_RESP |-> msgDone.length == 16'h0)
      else $error("response timeout closed a message");
   a_char_has_cause: assert property (
      msgChar.valid |-> $past(rxIn.valid)) else $error("char without input");
   a_bad_char_dropped: assert property (
      rxIn.valid && (rxIn.parityErr || rxIn.framingErr) |=> !msgChar.valid)
      else $error("bad char delivered");
   a_done_length_count: assert property (
      msgDone.valid && msgDone.code == `ERR_NONE |-> msgDone.length == cntNow)
      else $error("length differs from delivered count");
   a_max_length_end: assert property (
      msgChar.valid && endMask_q[`EC_MAX] && cntNow == maxLen_q
      |-> msgDone.valid) else $error("max length not ended");
   a_first_flag_order: assert property (
      msgChar.valid |-> msgChar.first == (cnt_q == 16'h0))
      else $error("first flag wrong");

   c_gap_end: cover property (msgDone.valid && msgDone.code == `ERR_GAP);
   c_resp_end: cover property (msgDone.valid && msgDone.code == `ERR_RESP);
   c_first_char: cover property (msgChar.valid && msgChar.first);
endmodule

bind serial_rx_message_delimiter serial_rx_message_delimiter_props #(
   .MS_CYCLES(MS_CYCLES)
) serial_rx_message_delimiter_props_inst (
   .core_clk(core_clk),
   .rst_n(rst_n),
   .clkEn(clkEn),
   .regAddr(regAddr),
   .regWdata(regWdata),
   .regWr(regWr),
   .regRd(regRd),
   .regRdata(regRdata),
   .rxIn(rxIn),
   .receiveRequest(receiveRequest),
   .msgChar(msgChar),
   .msgDone(msgDone)
);

// file: verification/tb.sv
// Purpose: Directed bench of the receive message framer
// Assumes: Millisecond shortened to 10 cycles, bit time to 4 cycles
// Notes:   Partner supplies characters and collects messages
`timescale 1ns/1ps
`include "srmd_cfg.svh"

module tb;
   import srmd_pkg::*;

   logic        core_clk;
   logic        rst_n;
   logic        clkEn;
   logic [7:0]  regAddr;
   logic [31:0] regWdata;
   logic        regWr;
   logic        regRd;
   logic [31:0] regRdata;
   rxChar_t     rxIn;
   logic        receiveRequest;
   msgChar_t    msgChar;
   msgDone_t    msgDone;
   int          fails;
   int          num_checks;
   int          cycles;
   logic [7:0]  expQ[$];

   serial_rx_message_delimiter #(
      .MS_CYCLES(10)
   ) serial_rx_message_delimiter_inst (
      .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .rxIn(rxIn), .receiveRequest(receiveRequest), .msgChar(msgChar),
      .msgDone(msgDone));
   serial_char_partner serial_char_partner_inst (
      .core_clk(core_clk), .rxIn(rxIn), .msgChar(msgChar), .msgDone(msgDone));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic close_out();
      if (fails == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input string what);
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1;
      chk(what, e, regRdata);
   endtask

   task automatic cfg(input logic [7:0] sm, input logic [5:0] em);
      wr(`RA_START_MASK, {24'h0, sm});
      wr(`RA_END_MASK, {26'h0, em});
   endtask

   task automatic tx(input logic [7:0] q[$]);
      foreach (q[i]) begin
         serial_char_partner_inst.send(q[i], 1'b0);
      end
   endtask

   // No message may end during a quiet stretch
   task automatic quiet(input int n);
      repeat (n) @(posedge core_clk);
      chk("early done", 0, serial_char_partner_inst.doneQ.size());
   endtask

   task automatic check_msg(input logic [15:0] len, input logic [1:0] code);
      int n;
      n = 0;
      while (serial_char_partner_inst.doneQ.size() == 0 && n < 400) begin
         @(posedge core_clk);
         n++;
      end
      #1;
      chk("done count", 1, serial_char_partner_inst.doneQ.size());
      if (serial_char_partner_inst.doneQ.size() > 0) begin
         chk("length", {16'h0, len}, serial_char_partner_inst.doneQ[0].length);
         chk("code", {30'h0, code}, serial_char_partner_inst.doneQ[0].code);
         chk("err", {31'h0, code != 2'h0},
             serial_char_partner_inst.doneQ[0].err);
      end
      chk("char count", expQ.size(), serial_char_partner_inst.gotQ.size());
      foreach (expQ[i]) begin
         if (i < serial_char_partner_inst.gotQ.size()) begin
            chk("data", expQ[i], serial_char_partner_inst.gotQ[i].data);
            chk("first", i == 0, serial_char_partner_inst.gotQ[i].first);
         end
      end
      serial_char_partner_inst.gotQ.delete();
      serial_char_partner_inst.doneQ.delete();
      expQ.delete();
   endtask

   // Hang guard; the whole run needs some 400 cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 8000) begin
         fails++;
         close_out();
      end
   end

   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      rst_n = 1'b0;
      clkEn = 1'b1;
      regAddr = 8'h00;
      regWdata = 32'h0;
      regWr = 1'b0;
      regRd = 1'b0;
      receiveRequest = 1'b0;
      fails = 0;
      num_checks = 0;
      cycles = 0;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(`RA_BAUD_DIV, 32'h5161, "baud reset");
      rd(`RA_LEN_SIZE, 32'h1, "size reset");
      wr(`RA_LEN_SIZE, 32'h3);
      rd(`RA_LEN_SIZE, 32'h1, "size refused");
      rd(8'hF0, 32'h0, "unmapped");
      rd(`RA_STATUS, 32'h0, "status idle");
      wr(`RA_BAUD_DIV, 32'h4);
      wr(`RA_MAX_LEN, 32'h2);
      cfg(8'h02, 6'h08);
      tx('{8'hA1, 8'hB2});
      expQ = '{8'hA1, 8'hB2};
      check_msg(16'h2, `ERR_NONE);
      wr(8'h40, 32'h68000068);
      wr(8'h44, 32'h00000900);
      cfg(8'h10, 6'h08);
      tx('{8'h68, 8'h10, 8'hAA, 8'h68, 8'hBB});
      expQ = '{8'h68, 8'hBB};
      check_msg(16'h2, `ERR_NONE);
      tx('{8'h68, 8'h10});
      serial_char_partner_inst.send(8'hAA, 1'b1);
      tx('{8'h68});
      quiet(40);
      chk("aborted chars", 0, serial_char_partner_inst.gotQ.size());
      wr(`RA_END_SEQ_LO, 32'h0A0D0000);
      wr(`RA_END_SEQ_HI, 32'h00000C00);
      cfg(8'h02, 6'h20);
      tx('{8'h0D, 8'h0A});
      quiet(4);
      tx('{8'h33});
      expQ = '{8'h0D, 8'h0A, 8'h33};
      check_msg(16'h3, `ERR_NONE);
      wr(`RA_LEN_POS, 32'h2);
      wr(`RA_LEN_SIZE, 32'h2);
      wr(`RA_LEN_TRAIL, 32'h1);
      cfg(8'h02, 6'h10);
      tx('{8'h55, 8'h00, 8'h02, 8'hD1, 8'hD2});
      quiet(4);
      tx('{8'hCC});
      expQ = '{8'h55, 8'h00, 8'h02, 8'hD1, 8'hD2, 8'hCC};
      check_msg(16'h6, `ERR_NONE);
      wr(`RA_GAP_BITS, 32'h3);
      wr(`RA_MAX_LEN, 32'hA);
      cfg(8'h02, 6'h0C);
      tx('{8'h41, 8'h42});
      expQ = '{8'h41, 8'h42};
      check_msg(16'h2, `ERR_GAP);
      wr(`RA_MSG_MS, 32'h2);
      cfg(8'h02, 6'h0A);
      tx('{8'h43});
      expQ = '{8'h43};
      check_msg(16'h1, `ERR_NONE);
      wr(`RA_RESP_MS, 32'h2);
      cfg(8'h02, 6'h09);
      @(posedge core_clk);
      receiveRequest <= 1'b1;
      @(posedge core_clk);
      receiveRequest <= 1'b0;
      check_msg(16'h0, `ERR_RESP);
      wr(`RA_IDLE_BITS, 32'h4);
      wr(`RA_MAX_LEN, 32'h1);
      cfg(8'h08, 6'h08);
      repeat (40) @(posedge core_clk);
      tx('{8'h51});
      expQ = '{8'h51};
      check_msg(16'h1, `ERR_NONE);
      tx('{8'h52});
      repeat (40) @(posedge core_clk);
      tx('{8'h53});
      expQ = '{8'h53};
      check_msg(16'h1, `ERR_NONE);
      wr(`RA_START_CHAR, 32'h7E);
      wr(`RA_MAX_LEN, 32'h2);
      cfg(8'h01, 6'h08);
      tx('{8'h11, 8'h22, 8'h7E, 8'h33});
      expQ = '{8'h7E, 8'h33};
      check_msg(16'h2, `ERR_NONE);
      cfg(8'h02, 6'h08);
      tx('{8'h61});
      serial_char_partner_inst.send(8'h62, 1'b1);
      expQ = '{8'h61};
      check_msg(16'h1, `ERR_LINE);
      cfg(8'h04, 6'h08);
      tx('{8'h71});
      serial_char_partner_inst.brk_pulse();
      tx('{8'h72, 8'h73});
      expQ = '{8'h72, 8'h73};
      check_msg(16'h2, `ERR_NONE);
      close_out();
   end
endmodule
